// ---- rtl/fpsf_regs.v ----
`include "fpsf_defines.vh"
`default_nettype none
// Overview of operation
// - fault flags latch, a read clears them unless a same-cycle event sets one
// - bit 3 shows clock-error block one fault
// - bit 2 shows clock-error block two fault
// - bit 7 set enters low-power shutdown
// - bank selector at 0x7F, resets to zero
// - page selector steers accesses, resets to one
// - page selector at address 0x00, every page
// - format field bits 7-5 selects framing
// - length field bits 4-3 sets sample width
// - bit 0 floats output after frame data
// - offset counted from frame clock rise, DSP
// - offset ignored in right-justified framing
module fpsf_regs (
  // clock and reset
  input wire i_sys_clk,
  input wire i_resetn,
  // control port access
  input wire [6:0] i_addr,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  output reg o_rvalid,
  // fault events, one-cycle pulses or levels
  input wire i_clock_fault_one,
  input wire i_clock_fault_two,
  // serial port frame state from the datapath
  input wire [5:0] i_frame_bit_count,
  // controls out
  output reg o_low_power_shutdown,
  output reg o_por_disable,
  output reg [7:0] o_bank,
  output reg [7:0] o_page,
  output reg [2:0] o_serial_format_select,
  output reg [5:0] o_serial_word_bits,
  output reg o_output_float_enable,
  output reg [8:0] o_first_bit_delay,
  output reg o_output_float_now
);

  ////////////////////////////////////////////////////////////////////////////
  // decode
  ////////////////////////////////////////////////////////////////////////////

  // true when the address names a register on the given page and bank
  function hit;
    input [6:0] addr;
    input [6:0] reg_addr;
    input [7:0] page;
    input [7:0] reg_page;
    input [7:0] bank;
    begin
      // only bank zero holds the paged registers
      hit = (addr == reg_addr) && (page == reg_page) && (bank == `FPSF_BANK_BASE);
    end
  endfunction

  // stored register values
  // selectors stay local as they decode on every page
  wire [7:0] format_q;
  wire [7:0] offset_q;
  wire [7:0] lowpwr_q;
  wire [7:0] fault_q;
  reg [7:0] page_q;
  reg [7:0] bank_q;

  // per-register hits
  wire hit_fmt;
  wire hit_off;
  wire hit_fault;
  wire hit_lp;
  wire hit_bank;
  wire hit_page;

  // page selector answers at address 0x00 on every page and bank
  // page always reachable
  assign hit_page = (i_addr == `FPSF_ADDR_PAGE);
  // bank selector answers on any page so the host can always switch back
  // bank at 0x7F
  assign hit_bank = (i_addr == `FPSF_ADDR_BANK);
  // serial port registers sit on page one, system ones on page zero
  // all four need bank zero as well
  assign hit_fmt = hit(i_addr, `FPSF_ADDR_FORMAT, page_q, `FPSF_PAGE_PORT, bank_q);
  assign hit_off = hit(i_addr, `FPSF_ADDR_OFFSET, page_q, `FPSF_PAGE_PORT, bank_q);
  assign hit_fault = hit(i_addr, `FPSF_ADDR_FAULT, page_q, `FPSF_PAGE_SYS, bank_q);
  assign hit_lp = hit(i_addr, `FPSF_ADDR_LOWPWR, page_q, `FPSF_PAGE_SYS, bank_q);

  ////////////////////////////////////////////////////////////////////////////
  // selectors
  ////////////////////////////////////////////////////////////////////////////

  // page and bank selectors
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      page_q <= `FPSF_RST_PAGE;
      bank_q <= `FPSF_RST_ZERO;
    end else begin
      if (i_wr && hit_page) begin
        page_q <= i_wdata;
      end
      // bank writes land on every page
      // any of 256 banks
      if (i_wr && hit_bank) begin
        bank_q <= i_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // plain control registers
  ////////////////////////////////////////////////////////////////////////////

  // serial format register, resets to 24-bit I2S, driven output
  // reserved bits 2-1 are kept read/write
  fpsf_reg_cell #(
    .RST(`FPSF_RST_FORMAT),
    .MASK(`FPSF_MASK_FORMAT)
  ) u_format (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_wr(i_wr && hit_fmt),
    .i_data(i_wdata),
    .o_q(format_q)
  );

  // data start offset register
  // the offset is ignored only in right-justified framing
  fpsf_reg_cell #(
    .RST(`FPSF_RST_ZERO),
    .MASK(`FPSF_MASK_FORMAT)
  ) u_offset (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_wr(i_wr && hit_off),
    .i_data(i_wdata),
    .o_q(offset_q)
  );

  // low-power control register
  // only bit 7 drives logic, the other bits just store
  fpsf_reg_cell #(
    .RST(`FPSF_RST_ZERO),
    .MASK(`FPSF_MASK_LOWPWR)
  ) u_lowpwr (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_wr(i_wr && hit_lp),
    .i_data(i_wdata),
    .o_q(lowpwr_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sticky clock-fault flags
  ////////////////////////////////////////////////////////////////////////////

  // event inputs in flag bit order
  // bit 3 is block one, bit 2 is block two
  wire [7:0] fault_evt;
  assign fault_evt = {4'h0, i_clock_fault_one, i_clock_fault_two, 2'h0};

  // one sticky bit per flag; a read clears, a same-cycle event wins
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_flag
      if (g == `FPSF_BIT_FAULT1 || g == `FPSF_BIT_FAULT2) begin : g_live
        reg flag;
        always @(posedge i_sys_clk or negedge i_resetn) begin
          if (!i_resetn) begin
            flag <= 1'b0;
          // a new event wins over a clearing read
          end else if (fault_evt[g]) begin
            flag <= 1'b1;
          // the read returns the old value, then clears
          end else if (i_rd && hit_fault) begin
            flag <= 1'b0;
          end
        end
        assign fault_q[g] = flag;
      end else begin : g_rsvd
        // reserved bits read as zero
        assign fault_q[g] = 1'b0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read port
  ////////////////////////////////////////////////////////////////////////////

  // read mux, unmapped reads return zero
  reg [7:0] next_rdata;
  always @* begin
    next_rdata = `FPSF_RST_ZERO;
    if (hit_page) begin
      next_rdata = page_q;
    end else if (hit_bank) begin
      next_rdata = bank_q;
    end else if (hit_fmt) begin
      next_rdata = format_q;
    end else if (hit_off) begin
      next_rdata = offset_q;
    end else if (hit_fault) begin
      next_rdata = fault_q;
    end else if (hit_lp) begin
      next_rdata = lowpwr_q;
    end
  end

  // read data registered one cycle after the strobe
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= `FPSF_RST_ZERO;
      o_rvalid <= 1'b0;
    end else begin
      // valid marks the cycle after each read strobe, when a new answer lands
      o_rvalid <= i_rd;
      // data holds until the next read
      if (i_rd) begin
        o_rdata <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // derived serial-port controls
  ////////////////////////////////////////////////////////////////////////////

  // sample width from the length field
  reg [5:0] next_bits;
  always @* begin
    // width decode
    // all four codes map to a width
    case (format_q[`FPSF_LEN_HI:`FPSF_LEN_LO])
      `FPSF_LEN_16: next_bits = `FPSF_W16;
      `FPSF_LEN_20: next_bits = `FPSF_W20;
      `FPSF_LEN_24: next_bits = `FPSF_W24;
      default: next_bits = `FPSF_W32;
    endcase
  end

  // first data bit position after the frame clock edge
  reg [8:0] next_delay;
  always @* begin
    next_delay = {1'b0, offset_q};
    case (format_q[`FPSF_FMT_HI:`FPSF_FMT_LO])
      // i2s has its one-bit nominal lag before the offset
      `FPSF_MODE_I2S: next_delay = `FPSF_NOM_I2S + {1'b0, offset_q};
      `FPSF_MODE_DSP: next_delay = `FPSF_NOM_NONE + {1'b0, offset_q};
      `FPSF_MODE_RJ: next_delay = `FPSF_NOM_NONE;
      // left-justified, mono and reserved codes
      // offset adds bit clocks
      default: next_delay = `FPSF_NOM_NONE + {1'b0, offset_q};
    endcase
  end

  // frame data has ended once past first-bit delay plus word width
  // ten bits wide so delay plus width never wraps
  wire [9:0] data_end;
  assign data_end = {1'b0, next_delay} + {4'h0, next_bits};

  // registered outputs
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      // outputs start at the values the registers reset to
      o_low_power_shutdown <= 1'b0;
      o_por_disable <= 1'b0;
      o_bank <= `FPSF_RST_ZERO;
      o_page <= `FPSF_RST_PAGE;
      o_serial_format_select <= `FPSF_MODE_I2S;
      o_serial_word_bits <= `FPSF_W24;
      o_output_float_enable <= 1'b0;
      o_first_bit_delay <= `FPSF_NOM_I2S;
      o_output_float_now <= 1'b0;
    end else begin
      o_low_power_shutdown <= lowpwr_q[`FPSF_BIT_SHDN];
      o_por_disable <= lowpwr_q[`FPSF_BIT_SHDN];
      // selector copies for the access steering outside
      o_bank <= bank_q;
      o_page <= page_q;
      o_serial_format_select <= format_q[`FPSF_FMT_HI:`FPSF_FMT_LO];
      o_serial_word_bits <= next_bits;
      o_output_float_enable <= format_q[`FPSF_BIT_FLOAT];
      o_output_float_now <= format_q[`FPSF_BIT_FLOAT] &&
        ({4'h0, i_frame_bit_count} >= data_end);
      // data start position for the serial datapath
      o_first_bit_delay <= next_delay;
    end
  end

endmodule // fpsf_regs
`default_nettype wire

// ---- rtl/fpsf_defines.vh ----
`ifndef FPSF_DEFINES_VH
`define FPSF_DEFINES_VH
// register addresses within a page
`define FPSF_ADDR_PAGE 7'h00
`define FPSF_ADDR_FORMAT 7'h01
`define FPSF_ADDR_OFFSET 7'h03
`define FPSF_ADDR_FAULT 7'h6C
`define FPSF_ADDR_LOWPWR 7'h79
`define FPSF_ADDR_BANK 7'h7F
// page holding each register
`define FPSF_PAGE_SYS 8'h00
`define FPSF_PAGE_PORT 8'h01
`define FPSF_BANK_BASE 8'h00
// reset values
`define FPSF_RST_PAGE 8'h01
`define FPSF_RST_FORMAT 8'h10
`define FPSF_RST_ZERO 8'h00
// field positions
`define FPSF_BIT_FAULT1 3
`define FPSF_BIT_FAULT2 2
`define FPSF_BIT_SHDN 7
`define FPSF_FMT_HI 7
`define FPSF_FMT_LO 5
`define FPSF_LEN_HI 4
`define FPSF_LEN_LO 3
`define FPSF_BIT_FLOAT 0
// writable bits of the format register (reserved 2-1 kept read/write)
`define FPSF_MASK_FORMAT 8'hFF
`define FPSF_MASK_LOWPWR 8'hFF
// framing codes
`define FPSF_MODE_I2S 3'h0
`define FPSF_MODE_DSP 3'h1
`define FPSF_MODE_RJ 3'h2
`define FPSF_MODE_LJ 3'h3
`define FPSF_MODE_PCM 3'h4
// word length codes and widths
`define FPSF_LEN_16 2'h0
`define FPSF_LEN_20 2'h1
`define FPSF_LEN_24 2'h2
`define FPSF_LEN_32 2'h3
`define FPSF_W16 6'h10
`define FPSF_W20 6'h14
`define FPSF_W24 6'h18
`define FPSF_W32 6'h20
// nominal first-bit delay per framing, bit clocks
`define FPSF_NOM_I2S 9'h001
`define FPSF_NOM_NONE 9'h000
`endif

// ---- rtl/fpsf_reg_cell.v ----
`default_nettype none
// one 8-bit control register with reset value and write mask
module fpsf_reg_cell #(
  parameter [7:0] RST = 8'h00,
  parameter [7:0] MASK = 8'hFF
) (
  // clock and reset
  input wire i_sys_clk,
  input wire i_resetn,
  // write port
  input wire i_wr,
  input wire [7:0] i_data,
  // stored value
  output reg [7:0] o_q
);
  // masked write, registered output
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_q <= RST;
    end else if (i_wr) begin
      o_q <= (i_data & MASK) | (o_q & ~MASK);
    end
  end
endmodule // fpsf_reg_cell
`default_nettype wire

// ---- tb/fpsf_regs_asserts.sv ----
`default_nettype none
// port watcher for the register group
module fpsf_regs_asserts (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire [6:0] i_addr,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] i_wdata,
  input wire i_clock_fault_one,
  input wire i_clock_fault_two,
  input wire [7:0] o_rdata,
  input wire o_rvalid,
  input wire o_low_power_shutdown,
  input wire o_por_disable,
  input wire [7:0] o_bank,
  input wire [7:0] o_page,
  input wire [2:0] o_serial_format_select,
  input wire [8:0] o_first_bit_delay
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // access to the system page of bank zero
  wire sys_rd = i_rd && o_page == 8'h00 && o_bank == 8'h00;
  wire sys_wr = i_wr && o_page == 8'h00 && o_bank == 8'h00;
  wire quiet = !i_clock_fault_one && !i_clock_fault_two;
  sequence flag_rd;
    sys_rd && i_addr == 7'h6C && quiet;
  endsequence
  a_rvalid_after_rd: assert property (i_rd |=> o_rvalid) else $error("no read answer");
  a_rvalid_only_rd: assert property (o_rvalid |-> $past(i_rd)) else $error("stray answer");
  a_flag_one_set: assert property (
    sys_rd && i_addr == 7'h6C && $past(i_clock_fault_one) |=> o_rdata[3]) else $error("flag1");
  a_flag_two_set: assert property (
    sys_rd && i_addr == 7'h6C && $past(i_clock_fault_two) |=> o_rdata[2]) else $error("flag2");
  a_flags_clear_read: assert property (
    flag_rd ##1 quiet ##1 flag_rd |=> o_rdata == 8'h00) else $error("flags kept");
  a_shutdown_follow: assert property (
    sys_wr && i_addr == 7'h79 |=> ##1 o_low_power_shutdown == $past(i_wdata[7], 2)
    && o_por_disable == $past(i_wdata[7], 2)) else $error("shutdown");
  a_bank_write: assert property (
    i_wr && i_addr == 7'h7F |=> ##1 o_bank == $past(i_wdata, 2)) else $error("bank");
  a_rj_no_offset: assert property (
    o_serial_format_select == 3'h2 |-> o_first_bit_delay == 9'h000) else $error("rj");
  a_unmapped_zero: assert property (
    sys_rd && i_addr == 7'h05 |=> o_rdata == 8'h00) else $error("unmapped");
endmodule // fpsf_regs_asserts
bind fpsf_regs fpsf_regs_asserts chk_u (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
  .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata),
  .i_clock_fault_one(i_clock_fault_one), .i_clock_fault_two(i_clock_fault_two),
  .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_low_power_shutdown(o_low_power_shutdown),
  .o_por_disable(o_por_disable), .o_bank(o_bank), .o_page(o_page),
  .o_serial_format_select(o_serial_format_select), .o_first_bit_delay(o_first_bit_delay));
`default_nettype wire

// ---- tb/fpsf_far_model.sv ----
`default_nettype none
// clock-error blocks and frame counter beside the register group
module fpsf_far_model (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // fault requests from the bench
  input wire logic [1:0] i_req,
  // fault events and frame position
  output logic o_fault_one,
  output logic o_fault_two,
  output logic [5:0] o_frame_bit_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // one-cycle fault pulses, free frame count
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_fault_one <= 1'b0;
      o_fault_two <= 1'b0;
      o_frame_bit_count <= 6'h00;
    end else begin
      o_fault_one <= i_req[0];
      o_fault_two <= i_req[1];
      o_frame_bit_count <= o_frame_bit_count + 6'h01;
    end
  end
endmodule // fpsf_far_model
`default_nettype wire

// ---- tb/tb_fpsf_regs.sv ----
`default_nettype none
module tb_fpsf_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [6:0] i_addr = 7'h00;
  logic [7:0] i_wdata = 8'h00;
  logic [1:0] req = 2'h0;
  logic f1, f2, rv, shdn, por, fen, fnow;
  logic [5:0] fbc, wbits;
  logic [7:0] rdata, bank, page;
  logic [2:0] fmt;
  logic [8:0] dly;
  int n_errors = 0, samples_checked = 0;
  fpsf_far_model far_u (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_req(req),
    .o_fault_one(f1), .o_fault_two(f2), .o_frame_bit_count(fbc));
  fpsf_regs dut_u (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(rdata), .o_rvalid(rv),
    .i_clock_fault_one(f1), .i_clock_fault_two(f2), .i_frame_bit_count(fbc),
    .o_low_power_shutdown(shdn), .o_por_disable(por), .o_bank(bank), .o_page(page),
    .o_serial_format_select(fmt), .o_serial_word_bits(wbits), .o_output_float_enable(fen),
    .o_first_bit_delay(dly), .o_output_float_now(fnow));
  // compare and count
  task chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  // read answer and valid checked together
  task rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    chk({rv, rdata}, {1'b1, e});
  endtask
  task flt(input logic [1:0] r);
    @(posedge i_sys_clk);
    req <= r;
    @(posedge i_sys_clk);
    req <= 2'h0;
  endtask
  task settle;
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask
  task results;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial forever #2 i_sys_clk = ~i_sys_clk;
  // hang guard
  initial begin
    #20000;
    n_errors++;
    results;
  end
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    rd(7'h00, 8'h01);
    rd(7'h01, 8'h10);
    rd(7'h03, 8'h00);
    wr(7'h00, 8'h00);
    rd(7'h7F, 8'h00);
    chk(9'(page), 9'h000);
    rd(7'h79, 8'h00);
    rd(7'h05, 8'h00);
    wr(7'h79, 8'h80);
    settle;
    chk(9'({shdn, por}), 9'h003);
    wr(7'h79, 8'h00);
    settle;
    chk(9'({shdn, por}), 9'h000);
    flt(2'h1);
    rd(7'h6C, 8'h08);
    rd(7'h6C, 8'h00);
    flt(2'h2);
    rd(7'h6C, 8'h04);
    flt(2'h3);
    rd(7'h6C, 8'h0C);
    wr(7'h7F, 8'hFF);
    flt(2'h1);
    rd(7'h6C, 8'h00);
    rd(7'h7F, 8'hFF);
    wr(7'h7F, 8'h00);
    rd(7'h6C, 8'h08);
    wr(7'h00, 8'h01);
    rd(7'h00, 8'h01);
    chk(9'(page), 9'h001);
    for (int m = 0; m < 5; m++) begin
      wr(7'h01, {m[2:0], 5'h10});
      settle;
      chk(9'(fmt), 9'(m));
    end
    for (int l = 0; l < 4; l++) begin
      wr(7'h01, {3'h1, l[1:0], 3'h0});
      settle;
      chk(9'(wbits), (l == 3) ? 9'h020 : 9'(16 + 4 * l));
    end
    // offset of 5 checked in I2S, DSP, right- and left-justified; right-justified ignores it
    wr(7'h03, 8'h05);
    for (int m = 0; m < 4; m++) begin
      wr(7'h01, {m[2:0], 5'h10});
      settle;
      chk(dly, (m == 0) ? 9'h006 : (m == 2) ? 9'h000 : 9'h005);
    end
    for (int e = 1; e >= 0; e--) begin
      wr(7'h01, {7'h08, e[0]});
      settle;
      chk(9'(fen), 9'(e));
      repeat (64) begin
        @(posedge i_sys_clk);
        #1;
        if (fbc == 6'd40) chk(9'(fnow), 9'(e));
        if (fbc == 6'd10) chk(9'(fnow), 9'h000);
      end
    end
    results;
  end
endmodule // tb_fpsf_regs
`default_nettype wire
